// File: rtl/cswg_pkg.sv
// Constants and carrier types for the per-socket status-change enables
// and card window gate. Assumes one system clock and byte-wide registers.
package cswg_pkg;

    // ------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------
    localparam int NUM_SOCK = 2;
    localparam int ADDR_W = 7;
    localparam int SOCK_BIT = 6;
    localparam int NUM_MEM_WIN = 5;
    localparam int NUM_IO_WIN = 2;
    localparam int IO_WIN_LSB = 6;

    // ------------------------------------------------------------
    // Register indices within one socket
    // ------------------------------------------------------------
    localparam logic [5:0] IDX_STATUS = 6'h04;
    localparam logic [5:0] IDX_IRQ_CFG = 6'h05;
    localparam logic [5:0] IDX_WIN_EN = 6'h06;
    localparam logic [5:0] IDX_IO_CTL = 6'h07;

    // ------------------------------------------------------------
    // Reset values and field layout
    // ------------------------------------------------------------
    localparam logic [7:0] RST_WIN_EN = 8'h00;
    localparam logic [7:0] RST_IO_CTL = 8'h00;
    localparam logic [7:0] RST_IRQ_CFG = 8'h00;
    localparam logic [3:0] RST_FLAGS = 4'h0;
    localparam logic [7:0] WIN_EN_MASK = 8'hdf;
    localparam int WIN_RSVD_BIT = 5;
    localparam int BIT_CD = 3;
    localparam int BIT_READY = 2;
    localparam int BIT_BWARN = 1;
    localparam int BIT_BDEAD = 0;
    localparam logic [3:0] IO_CARD_MASK = 4'h9;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic card_detect_line_a;
        logic card_detect_line_b;
        logic ready;
        logic battery_warning;
        logic battery_dead_or_status_change;
        logic io_card;
    } cswg_card_t;

    typedef struct packed {
        logic card_detect_changed;
        logic ready_rise;
        logic battery_warning;
        logic battery_dead;
    } cswg_evt_t;

endpackage : cswg_pkg

// File: rtl/cswg_evt_det.sv
// Card line event detector for one socket.
// Assumes card lines are synchronous to the clock.
`timescale 1ns/100ps
module cswg_evt_det
    import cswg_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Card lines
    input cswg_card_t card,
    // Events, one-cycle pulses
    output cswg_evt_t evt
);

    // ------------------------------------------------------------
    // Edge detection
    // ------------------------------------------------------------
    cswg_card_t prev_q;
    cswg_card_t prev_d;
    logic primed_q;
    logic primed_d;
    cswg_evt_t evt_q;
    cswg_evt_t evt_d;

    always_comb
    begin
        prev_d = card;
        primed_d = 1'b1;
        evt_d.card_detect_changed = primed_q &
            ((card.card_detect_line_a ^ prev_q.card_detect_line_a) |
             (card.card_detect_line_b ^ prev_q.card_detect_line_b));
        evt_d.ready_rise = primed_q & card.ready & ~prev_q.ready & ~card.io_card;
        evt_d.battery_warning = primed_q & card.battery_warning &
            ~prev_q.battery_warning & ~card.io_card;
        evt_d.battery_dead = primed_q & card.battery_dead_or_status_change &
            ~prev_q.battery_dead_or_status_change;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            prev_q <= '0;
            primed_q <= 1'b0;
            evt_q <= '0;
        end
        else
        begin
            prev_q <= prev_d;
            primed_q <= primed_d;
            evt_q <= evt_d;
        end
    end

    assign evt = evt_q;

endmodule : cswg_evt_det

// File: rtl/cswg_regs.sv
// Status-change enables, flags and window gate for two card sockets.
// Assumes an outer decoder strips the socket base plus 800h and that an
// outer window comparator reports which window a cycle hits.
`timescale 1ns/100ps
module cswg_regs
    import cswg_pkg::*;
(
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic RST,
    // Register port
    input wire logic REG_RD,
    input wire logic REG_WR,
    input wire logic [ADDR_W-1:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    output logic [7:0] REG_RDATA,
    output logic REG_RVALID,
    // Card lines
    input cswg_card_t [NUM_SOCK-1:0] CARD,
    // Host cycle to a card window
    input wire logic CYC_VALID,
    input wire logic CYC_SOCK,
    input wire logic CYC_IS_IO,
    input wire logic [2:0] CYC_WIN,
    output logic CYC_CLAIM,
    // Socket state
    output logic [NUM_SOCK-1:0][7:0] WIN_EN,
    output logic [NUM_SOCK-1:0][7:0] IO_WIN_CTRL,
    output logic [NUM_SOCK-1:0] CSC_IRQ
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic win_hit(input logic [7:0] en, input logic is_io,
                                     input logic [2:0] win);
        logic hit;
        hit = 1'b0;
        if (is_io)
        begin
            if (win < 3'(NUM_IO_WIN))
                hit = en[IO_WIN_LSB + int'(win)];
        end
        else if (win < 3'(NUM_MEM_WIN))
        begin
            hit = en[win];
        end
        return hit;
    endfunction : win_hit

    function automatic logic [3:0] flag_view(input logic [3:0] f, input logic io_card);
        return io_card ? (f & IO_CARD_MASK) : f;
    endfunction : flag_view

    // ------------------------------------------------------------
    // Event detectors
    // ------------------------------------------------------------
    cswg_evt_t [NUM_SOCK-1:0] evt;

    genvar gs;
    generate
        for (gs = 0; gs < NUM_SOCK; gs++)
        begin : g_det
            cswg_evt_det u_det (
                .clk(CLK_SYS),
                .rst(RST),
                .card(CARD[gs]),
                .evt(evt[gs])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Socket registers
    // ------------------------------------------------------------
    logic [NUM_SOCK-1:0][7:0] win_en_q;
    logic [NUM_SOCK-1:0][7:0] win_en_d;
    logic [NUM_SOCK-1:0][7:0] io_ctl_q;
    logic [NUM_SOCK-1:0][7:0] io_ctl_d;
    logic [NUM_SOCK-1:0][7:0] cfg_q;
    logic [NUM_SOCK-1:0][7:0] cfg_d;
    logic [NUM_SOCK-1:0][3:0] flag_q;
    logic [NUM_SOCK-1:0][3:0] flag_d;
    logic [NUM_SOCK-1:0] irq_q;
    logic [NUM_SOCK-1:0] irq_d;

    always_comb
    begin
        for (int s = 0; s < NUM_SOCK; s++)
        begin
            logic sel;
            logic [3:0] ev;
            sel = (REG_ADDR[SOCK_BIT] == 1'(s));
            ev = evt[s];
            win_en_d[s] = win_en_q[s];
            io_ctl_d[s] = io_ctl_q[s];
            cfg_d[s] = cfg_q[s];
            flag_d[s] = flag_q[s];
            if (REG_WR && sel && REG_ADDR[5:0] == IDX_WIN_EN)
                win_en_d[s] = REG_WDATA & WIN_EN_MASK;
            if (REG_WR && sel && REG_ADDR[5:0] == IDX_IO_CTL)
                io_ctl_d[s] = REG_WDATA;
            if (REG_WR && sel && REG_ADDR[5:0] == IDX_IRQ_CFG)
                cfg_d[s] = REG_WDATA;
            if (REG_RD && sel && REG_ADDR[5:0] == IDX_STATUS)
                flag_d[s] = RST_FLAGS;
            else if (REG_WR && sel && REG_ADDR[5:0] == IDX_STATUS)
                flag_d[s] = flag_q[s] & ~REG_WDATA[3:0];
            flag_d[s] = flag_d[s] | ev;
            flag_d[s] = flag_view(flag_d[s], CARD[s].io_card);
            irq_d[s] = |(flag_q[s] & cfg_q[s][3:0]);
        end
    end

    always_ff @(posedge CLK_SYS or posedge RST)
    begin
        if (RST)
        begin
            for (int s = 0; s < NUM_SOCK; s++)
            begin
                win_en_q[s] <= RST_WIN_EN;
                io_ctl_q[s] <= RST_IO_CTL;
                cfg_q[s] <= RST_IRQ_CFG;
                flag_q[s] <= RST_FLAGS;
            end
            irq_q <= '0;
        end
        else
        begin
            win_en_q <= win_en_d;
            io_ctl_q <= io_ctl_d;
            cfg_q <= cfg_d;
            flag_q <= flag_d;
            irq_q <= irq_d;
        end
    end

    // ------------------------------------------------------------
    // Read port and window claim
    // ------------------------------------------------------------
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic rvalid_q;
    logic rvalid_d;
    logic claim_q;
    logic claim_d;

    always_comb
    begin
        logic rs;
        rs = REG_ADDR[SOCK_BIT];
        rdata_d = 8'h00;
        rvalid_d = REG_RD;
        if (REG_RD)
        begin
            if (REG_ADDR[5:0] == IDX_STATUS)
                rdata_d = {4'h0, flag_view(flag_q[rs], CARD[rs].io_card)};
            else if (REG_ADDR[5:0] == IDX_IRQ_CFG)
                rdata_d = cfg_q[rs];
            else if (REG_ADDR[5:0] == IDX_WIN_EN)
                rdata_d = win_en_q[rs] & WIN_EN_MASK;
            else if (REG_ADDR[5:0] == IDX_IO_CTL)
                rdata_d = io_ctl_q[rs];
        end
        claim_d = CYC_VALID && win_hit(win_en_q[CYC_SOCK], CYC_IS_IO, CYC_WIN);
    end

    always_ff @(posedge CLK_SYS or posedge RST)
    begin
        if (RST)
        begin
            rdata_q <= 8'h00;
            rvalid_q <= 1'b0;
            claim_q <= 1'b0;
        end
        else
        begin
            rdata_q <= rdata_d;
            rvalid_q <= rvalid_d;
            claim_q <= claim_d;
        end
    end

    assign REG_RDATA = rdata_q;
    assign REG_RVALID = rvalid_q;
    assign CYC_CLAIM = claim_q;
    assign WIN_EN = win_en_q;
    assign IO_WIN_CTRL = io_ctl_q;
    assign CSC_IRQ = irq_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_claim_gate: assert property (@(posedge CLK_SYS) disable iff (RST)
        CYC_VALID && !win_hit(win_en_q[CYC_SOCK], CYC_IS_IO, CYC_WIN) |=> !CYC_CLAIM)
        else $error("Cycle claimed on a disabled window");
    chk_claim_io: assert property (@(posedge CLK_SYS) disable iff (RST)
        CYC_VALID && CYC_IS_IO && CYC_WIN == 3'h1 && WIN_EN[CYC_SOCK][7] |=> CYC_CLAIM)
        else $error("Enabled I/O window 1 not claimed");
    chk_claim_mem: assert property (@(posedge CLK_SYS) disable iff (RST)
        CYC_VALID && !CYC_IS_IO && CYC_WIN == 3'h4 && WIN_EN[CYC_SOCK][4] |=> CYC_CLAIM)
        else $error("Enabled memory window 4 not claimed");
    chk_rsvd_read: assert property (@(posedge CLK_SYS) disable iff (RST)
        REG_RD && REG_ADDR[5:0] == IDX_WIN_EN |=> !REG_RDATA[WIN_RSVD_BIT] && REG_RVALID)
        else $error("Reserved enable bit read as one");

    generate
        for (gs = 0; gs < NUM_SOCK; gs++)
        begin : g_chk
            chk_win_write: assert property (@(posedge CLK_SYS) disable iff (RST)
                REG_WR && REG_ADDR == {1'(gs), IDX_WIN_EN}
                |=> WIN_EN[gs] == ($past(REG_WDATA) & WIN_EN_MASK))
                else $error("Window enable write not taken");
            chk_ioctl_write: assert property (@(posedge CLK_SYS) disable iff (RST)
                REG_WR && REG_ADDR == {1'(gs), IDX_IO_CTL} |=> IO_WIN_CTRL[gs] == $past(REG_WDATA))
                else $error("I/O window control write not taken");
            chk_flag_clear: assert property (@(posedge CLK_SYS) disable iff (RST)
                REG_RD && REG_ADDR == {1'(gs), IDX_STATUS} && evt[gs] == '0 |=> flag_q[gs] == 4'h0)
                else $error("Status read did not clear flags");
            chk_io_mask: assert property (@(posedge CLK_SYS) disable iff (RST)
                CARD[gs].io_card |=> flag_q[gs][2:1] == 2'b00)
                else $error("Memory-only flag set with I/O card");
            chk_irq_raise: assert property (@(posedge CLK_SYS) disable iff (RST)
                evt[gs].card_detect_changed && cfg_q[gs][BIT_CD] &&
                !(REG_WR && REG_ADDR == {1'(gs), IDX_IRQ_CFG})
                |=> ##1 CSC_IRQ[gs])
                else $error("Enabled card detect change gave no request");
            chk_irq_mask: assert property (@(posedge CLK_SYS) disable iff (RST)
                (cfg_q[gs][3:0] == 4'h0) |=> !CSC_IRQ[gs])
                else $error("Request raised with all enables clear");
            chk_irq_drop: assert property (@(posedge CLK_SYS) disable iff (RST)
                (flag_q[gs] & cfg_q[gs][3:0]) == 4'h0 |=> !CSC_IRQ[gs])
                else $error("Request stands with no enabled flag");
        end
    endgenerate

endmodule : cswg_regs

// File: tb/cswg_card_model.sv
// Card line model for two sockets: holds line levels, toggles them on command.
// Assumes commands arrive synchronous to the system clock.
`timescale 1ns/100ps
module cswg_card_model
    import cswg_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Toggle command
    input wire logic tgl_valid,
    input wire logic tgl_sock,
    input wire logic [5:0] tgl_mask,
    // Card lines
    output cswg_card_t [NUM_SOCK-1:0] card
);
    cswg_card_t [NUM_SOCK-1:0] card_q;
    assign card = card_q;
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            card_q <= '0;
        else if (tgl_valid)
            card_q[tgl_sock] <= cswg_card_t'(card_q[tgl_sock] ^ tgl_mask);
    end
endmodule : cswg_card_model

// File: tb/cswg_regs_test.sv
// Self-checking bench for the status-change enables and window gate.
// Assumes the card model drives the card lines of both sockets.
`timescale 1ns/100ps
module cswg_regs_test;
    import cswg_pkg::*;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic reg_rd = 1'b0, reg_wr = 1'b0, cyc_valid = 1'b0, cyc_sock = 1'b0, cyc_is_io = 1'b0;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [7:0] reg_wdata = '0, reg_rdata;
    logic reg_rvalid, cyc_claim, cv_q = 1'b0, tgl_v = 1'b0, tgl_s = 1'b0;
    logic [2:0] cyc_win = '0;
    logic [5:0] tgl_m = '0;
    logic [NUM_SOCK-1:0][7:0] win_en, io_ctl;
    logic [NUM_SOCK-1:0] csc_irq;
    cswg_card_t [NUM_SOCK-1:0] card;
    logic [7:0] rd_q[$], cl_q[$], en_s[2];
    logic [15:0] lf = 16'h2a00;
    int num_errors = 0, cmp_count = 0, cyc_n = 0;
    int cbit[4] = '{1, 2, 3, 5};

    always #50 clk_sys = ~clk_sys;

    cswg_regs u_dut (.CLK_SYS(clk_sys), .RST(rst), .REG_RD(reg_rd), .REG_WR(reg_wr),
        .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata),
        .REG_RVALID(reg_rvalid), .CARD(card), .CYC_VALID(cyc_valid), .CYC_SOCK(cyc_sock),
        .CYC_IS_IO(cyc_is_io), .CYC_WIN(cyc_win), .CYC_CLAIM(cyc_claim), .WIN_EN(win_en),
        .IO_WIN_CTRL(io_ctl), .CSC_IRQ(csc_irq));
    cswg_card_model u_card (.clk(clk_sys), .rst(rst), .tgl_valid(tgl_v),
        .tgl_sock(tgl_s), .tgl_mask(tgl_m), .card(card));

    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr_next

    task automatic test_done();
        $display("compares %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : test_done

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
            num_errors++;
        end
    endtask : chk

    task automatic waitc(input int n);
        repeat (n) @(posedge clk_sys);
        #10;
    endtask : waitc

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        if (a[5:0] == IDX_WIN_EN)
            en_s[a[6]] = d & WIN_EN_MASK;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        rd_q.push_back(e);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
    endtask : rd

    task automatic cyc(input logic s, input logic io, input logic [2:0] w);
        logic [7:0] e;
        e = io ? {7'h00, w < 2 && en_s[s][IO_WIN_LSB + w[0]]} : {7'h00, w < 5 && en_s[s][w]};
        @(posedge clk_sys);
        cl_q.push_back(e);
        cyc_valid <= 1'b1;
        cyc_sock <= s;
        cyc_is_io <= io;
        cyc_win <= w;
        @(posedge clk_sys);
        cyc_valid <= 1'b0;
    endtask : cyc

    task automatic tgl(input logic s, input logic [5:0] m);
        @(posedge clk_sys);
        tgl_v <= 1'b1;
        tgl_s <= s;
        tgl_m <= m;
        @(posedge clk_sys);
        tgl_v <= 1'b0;
    endtask : tgl

    // ----------------------------------------
    // Result monitor and timeout
    // ----------------------------------------
    always @(posedge clk_sys)
    begin
        cv_q <= cyc_valid;
        cyc_n++;
        if (reg_rvalid === 1'b1)
            chk(reg_rdata, rd_q.size() > 0 ? rd_q.pop_front() : 8'hxx);
        if (cv_q === 1'b1)
            chk({7'h00, cyc_claim}, cl_q.pop_front());
        if (cyc_n == 20000)
        begin
            num_errors++;
            test_done();
        end
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        en_s = '{8'h00, 8'h00};
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        foreach (cbit[i]) rd({i[0], 6'h04 + 6'(i)}, 8'h00);
        rd(7'h46, 8'h00);
        rd(7'h47, 8'h00);
        for (int w = 0; w < 5; w++) cyc(w[0], w < 2, 3'(w));
        $display("reset values done");
        wr(7'h06, 8'hff);
        rd(7'h06, 8'hdf);
        rd(7'h46, 8'h00);
        for (int b = 0; b < 8; b++)
        begin
            if (b == WIN_RSVD_BIT)
                continue;
            wr(7'h06, 8'h01 << b);
            for (int w = 0; w < 5; w++) cyc(1'b0, 1'b0, 3'(w));
            for (int w = 0; w < 3; w++) cyc(1'b0, 1'b1, 3'(w));
            cyc(1'b1, b > 5, 3'(b & 1));
        end
        $display("window gate done");
        for (int i = 0; i < 8; i++)
        begin
            lf = lfsr_next(lf);
            wr(7'h46, lf[7:0]);
            wr(7'h47, lf[15:8]);
            rd(7'h46, lf[7:0] & 8'hdf);
            rd(7'h47, lf[15:8]);
            chk(win_en[1], lf[7:0] & 8'hdf);
            chk(io_ctl[1], lf[15:8]);
            cyc(1'b1, lf[3], lf[2:0]);
        end
        $display("random access done");
        chk(win_en[0], 8'h80);
        chk(io_ctl[0], 8'h00);
        waitc(2);
        rst <= 1'b1;
        waitc(2);
        rst <= 1'b0;
        en_s = '{8'h00, 8'h00};
        chk(win_en[1], 8'h00);
        chk(io_ctl[1], 8'h00);
        rd(7'h46, 8'h00);
        $display("mid-run reset done");
        for (int b = 0; b < 4; b++)
        begin
            for (int en = 1; en >= 0; en--)
            begin
                wr(7'h05, 8'(en) << b);
                tgl(1'b0, 6'h01 << cbit[b]);
                waitc(5);
                chk({7'h00, csc_irq[0]}, 8'(en));
                rd(7'h04, 8'h01 << b);
                waitc(3);
                chk({7'h00, csc_irq[0]}, 8'h00);
                tgl(1'b0, 6'h01 << cbit[b]);
                waitc(5);
                wr(7'h04, 8'h0f);
                rd(7'h04, 8'h00);
            end
        end
        $display("status change done");
        wr(7'h45, 8'ha8);
        rd(7'h45, 8'ha8);
        tgl(1'b1, 6'h10);
        waitc(5);
        chk({7'h00, csc_irq[1]}, 8'h01);
        chk({7'h00, csc_irq[0]}, 8'h00);
        rd(7'h44, 8'h08);
        waitc(3);
        chk({7'h00, csc_irq[1]}, 8'h00);
        $display("second socket done");
        tgl(1'b0, 6'h01);
        wr(7'h05, 8'h06);
        tgl(1'b0, 6'h0c);
        waitc(5);
        chk({7'h00, csc_irq[0]}, 8'h00);
        rd(7'h04, 8'h00);
        wr(7'h05, 8'h01);
        tgl(1'b0, 6'h02);
        waitc(5);
        chk({7'h00, csc_irq[0]}, 8'h01);
        rd(7'h04, 8'h01);
        waitc(4);
        $display("io card done");
        test_done();
    end
endmodule : cswg_regs_test
